// file: bench/psq_program_sequencer_assertions.sv
// port-level checks of the program sequencer
`timescale 1ns/1ps
`include "psq_defines.vh"
module psq_program_sequencer_assertions (
  input logic        clk_sys,
  input logic        rstn,
  input logic        hreadyout,
  input logic        hresp,
  input logic        opValid,
  input logic        opReady,
  input logic [4:0]  opCode,
  input logic [1:0]  opLen,
  input logic [13:0] opTarget,
  input logic [3:0]  opData,
  input logic [13:0] romAddr,
  input logic [9:0]  romData,
  input logic [7:0]  tableData,
  input logic        tableDone,
  input logic [7:0]  portD,
  input logic [79:0] segOn
);
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  logic       tblWait_q;
  logic [8:0] ptr_q;
  wire taken = opValid && opReady;
  // opReady low outside a table wait means an interrupt
  wire irqTake = !opReady && !tblWait_q;
  // the pointer mirror ignores rti restores
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tblWait_q <= 1'h0;
      ptr_q     <= 9'h0;
    end else begin
      tblWait_q <= taken && opCode == `PSQ_OP_TABLE;
      if (taken && opCode == `PSQ_OP_LDPTR)
        ptr_q <= opTarget[8:0];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or okay");
  a_seq_advance: assert property (
    taken && opCode inside {`PSQ_OP_SEQ, `PSQ_OP_LDPTR, `PSQ_OP_RAMWR, `PSQ_OP_DI}
    |=> romAddr == $past(romAddr) + {12'h0, $past(opLen)})
    else $error("counter advance wrong");
  a_branch_load: assert property (
    taken && opCode == `PSQ_OP_BRANCH |=> romAddr == $past(opTarget))
    else $error("branch target not loaded");
  a_page_two: assert property (
    taken && opCode == `PSQ_OP_P2CALL |=> romAddr == {`PSQ_PAGE_TWO, $past(opTarget[6:0])})
    else $error("page two call wrong");
  a_table_fetch: assert property (
    taken && opCode == `PSQ_OP_TABLE
    |=> (!opReady && romAddr[12:0] == {$past(opTarget[5:0]), $past(opTarget[9:7]), $past(opData)})
    ##1 (tableDone && tableData == $past(romData[7:0])))
    else $error("table read wrong");
  a_irq_vector: assert property (
    irqTake |=> romAddr[13:4] == 10'h008 && !romAddr[0])
    else $error("no vector loaded");
  a_irq_gate_off: assert property (
    irqTake |=> opReady)
    else $error("interrupt not blocked");
  a_port_bit: assert property (
    taken && opCode inside {`PSQ_OP_PBSET, `PSQ_OP_PBCLR}
    |=> portD[$past(ptr_q[2:0])] == ($past(opCode) == `PSQ_OP_PBSET))
    else $error("port bit wrong");
  a_seg_write: assert property (
    taken && opCode == `PSQ_OP_RAMWR && ptr_q == 9'h1c8 |-> ##2 segOn[3:0] == $past(opData, 2))
    else $error("segment not following ram");
endmodule // psq_program_sequencer_assertions

bind psq_program_sequencer psq_program_sequencer_assertions psq_program_sequencer_assertions_inst (
  .clk_sys(clk_sys), .rstn(rstn), .hreadyout(hreadyout), .hresp(hresp), .opValid(opValid),
  .opReady(opReady), .opCode(opCode), .opLen(opLen), .opTarget(opTarget), .opData(opData),
  .romAddr(romAddr), .romData(romData), .tableData(tableData), .tableDone(tableDone),
  .portD(portD), .segOn(segOn));

// file: bench/psq_program_sequencer_tb_top.sv
// self-checking bench of the program sequencer
`timescale 1ns/1ps
`include "psq_defines.vh"
module psq_program_sequencer_tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_sys = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0, opValid = 1'h0;
  logic        ctxCarryIn = 1'h0, ctxSkipIn = 1'h0, bank;
  logic        hready, hreadyout, hresp, opReady, tableDone, skipHit;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, opLen = 2'h1, l;
  logic [2:0]  hsize = 3'h2, sp0;
  logic [4:0]  opCode = 5'h0;
  logic [13:0] opTarget = 14'h0, romAddr, pc, t;
  logic [3:0]  opData = 4'h0, ctxAIn = 4'h0, ctxBIn = 4'h0, ramRdData, d;
  logic [7:0]  irqReq = 8'h0, tableData, portD;
  logic [9:0]  romData, ctx;
  logic [8:0]  ptr;
  logic [79:0] segOn;
  integer      seed = 32'hc9e6, failCount = 0, samplesChecked = 0, cycles = 0, i, j, a, b, s;

  assign hready = hreadyout;
  always #12.5 clk_sys = ~clk_sys;

  psq_program_sequencer psq_program_sequencer_inst (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .opValid(opValid), .opReady(opReady), .opCode(opCode), .opLen(opLen), .opTarget(opTarget), .opData(opData),
    .irqReq(irqReq), .ctxCarryIn(ctxCarryIn), .ctxSkipIn(ctxSkipIn), .ctxAIn(ctxAIn), .ctxBIn(ctxBIn),
    .ctxRestore(), .ctxCarryOut(), .ctxSkipOut(), .ctxAOut(), .ctxBOut(), .romAddr(romAddr),
    .romData(romData), .tableData(tableData), .tableDone(tableDone), .ramRdData(ramRdData),
    .skipHit(skipHit), .portD(portD), .segOn(segOn));
  psq_rom_model psq_rom_model_inst (.romAddr(romAddr), .romData(romData));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] romByte(input logic [13:0] x);
    romByte = x[7:0] ^ x[13:6];
  endfunction

  task completeRun;
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one word transfer; read data taken at the data phase's end
  task bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    hsel <= 1'h1;
    haddr <= addr;
    hwrite <= wr;
    htrans <= `PSQ_HTRANS_NSEQ;
    do @(posedge clk_sys); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'h1);
    rd = hrdata;
  endtask

  // returns one edge after the take
  task op(input logic [4:0] c, input logic [1:0] n, input logic [13:0] tg, input logic [3:0] dat);
    opValid <= 1'h1;
    opCode <= c;
    opLen <= n;
    opTarget <= tg;
    opData <= dat;
    do @(posedge clk_sys); while (opReady !== 1'h1);
    opValid <= 1'h0;
    @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      completeRun;
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    for (i = 0; i < 8; i++) begin
      pc = {7'($random(seed)), 7'h7c};
      op(`PSQ_OP_BRANCH, 2'h1, pc, 4'h0);
      chk("branch", pc, romAddr);
      for (j = 0; j < 3; j++) begin
        l = 2'h1 + 2'($random(seed) & 1);
        pc = pc + l;
        op(`PSQ_OP_SEQ, l, 14'h0, 4'h0);
        chk("advance", pc, romAddr);
      end
      t = 14'($random(seed));
      op(`PSQ_OP_CALL, 2'h2, t, 4'h0);
      chk("call", t, romAddr);
      op(`PSQ_OP_RET, 2'h1, 14'h0, 4'h0);
      chk("return", pc + 14'h2, romAddr);
      t = 14'($random(seed)) & 14'h7f;
      op(`PSQ_OP_P2CALL, 2'h1, t, 4'h0);
      chk("page two call", {`PSQ_PAGE_TWO, t[6:0]}, romAddr);
      op(`PSQ_OP_RET, 2'h1, 14'h0, 4'h0);
      chk("page two return", pc + 14'h3, romAddr);
    end
    for (i = 0; i < 4; i++) begin
      bank = ~i[0];
      if (i < 2)
        op(bank ? `PSQ_OP_BANKHI : `PSQ_OP_BANKLO, 2'h1, 14'h0, 4'h0);
      else
        bus(1'h1, `PSQ_REG_CTRL, {31'h0, bank});
      bus(1'h0, `PSQ_REG_CTRL, 32'h0);
      chk("bank", bank, rd[0]);
      t = 14'($random(seed)) & 14'h3bf;
      d = 4'($random(seed));
      op(`PSQ_OP_TABLE, 2'h1, t, d);
      @(posedge clk_sys);
      chk("table", romByte({bank, t[5:0], t[9:7], d}), tableData);
    end
    for (i = 0; i < 8; i++) begin
      ptr = 9'($random(seed));
      d = 4'($random(seed));
      l = 2'($random(seed));
      op(`PSQ_OP_LDPTR, 2'h1, {5'h0, ptr}, 4'h0);
      op(`PSQ_OP_RAMWR, 2'h1, 14'h0, d);
      op(`PSQ_OP_RBSET, 2'h1, 14'h0, {2'h0, l});
      op(`PSQ_OP_RBTEST, 2'h1, 14'h0, {2'h0, l});
      chk("bit test set", 1'h0, skipHit);
      op(`PSQ_OP_RBCLR, 2'h1, 14'h0, {2'h0, l});
      op(`PSQ_OP_RBTEST, 2'h1, 14'h0, {2'h0, l});
      chk("bit test clear", 1'h1, skipHit);
      d[l] = 1'h0;
      repeat (2) @(posedge clk_sys);
      chk("ram word", d, ramRdData);
      op(`PSQ_OP_PBSET, 2'h1, 14'h0, 4'h0);
      chk("port bit set", 1'h1, portD[ptr[2:0]]);
      op(`PSQ_OP_PBTEST, 2'h1, 14'h0, 4'h0);
      chk("port bit test", 1'h0, skipHit);
      op(`PSQ_OP_PBCLR, 2'h1, 14'h0, 4'h0);
      chk("port bit clear", 1'h0, portD[ptr[2:0]]);
      s = {$random(seed)} % 20;
      op(`PSQ_OP_LDPTR, 2'h1, {5'h1, 4'hc + 4'(s / 8), 4'h8 + 4'(s % 8)}, 4'h0);
      op(`PSQ_OP_RAMWR, 2'h1, 14'h0, d);
      repeat (2) @(posedge clk_sys);
      chk("segment", d, segOn[4 * s +: 4]);
    end
    bus(1'h1, `PSQ_REG_MASKONE, 32'hf);
    bus(1'h1, `PSQ_REG_MASKTWO, 32'hf);
    for (i = 0; i < 6; i++) begin
      a = {$random(seed)} % 7;
      b = a + 1 + {$random(seed)} % (7 - a);
      ctx = 10'($random(seed));
      {ctxCarryIn, ctxSkipIn, ctxBIn, ctxAIn} <= ctx;
      irqReq <= (8'h1 << a) | (8'h1 << b);
      @(posedge clk_sys);
      irqReq <= 8'h0;
      bus(1'h0, `PSQ_REG_STATUS, 32'h0);
      sp0 = rd[17:15];
      op(`PSQ_OP_EI, 2'h1, 14'h0, 4'h0);
      op(`PSQ_OP_SEQ, 2'h1, 14'h0, 4'h0);
      repeat (3) @(posedge clk_sys);
      chk("vector", 32'h80 + 2 * a, romAddr);
      bus(1'h0, `PSQ_REG_FLAGS, 32'h0);
      chk("flags left", 8'h1 << b, rd[7:0]);
      bus(1'h0, `PSQ_REG_STATUS, 32'h0);
      chk("enable cleared", 1'h0, rd[18]);
      chk("stack push", 3'(sp0 + 3'h1), rd[17:15]);
      bus(1'h0, `PSQ_REG_CONTEXT, 32'h0);
      chk("context", ctx, rd[18:9]);
      bus(1'h1, `PSQ_REG_FLAGS, 32'h1 << b);
    end
    // enables off: sources are polled
    bus(1'h1, `PSQ_REG_MASKONE, 32'h0);
    bus(1'h1, `PSQ_REG_MASKTWO, 32'h0);
    for (i = 0; i < 8; i++) begin
      irqReq <= 8'h1 << i;
      @(posedge clk_sys);
      irqReq <= 8'h0;
      op(`PSQ_OP_EI, 2'h1, 14'h0, 4'h0);
      pc = romAddr;
      op(`PSQ_OP_SEQ, 2'h1, 14'h0, 4'h0);
      repeat (3) @(posedge clk_sys);
      chk("masked", pc + 14'h1, romAddr);
      bus(1'h0, `PSQ_REG_STATUS, 32'h0);
      chk("enable set", 1'h1, rd[18]);
      op(`PSQ_OP_IRQTEST, 2'h1, 14'h0, i[3:0]);
      chk("poll skip", 1'h1, skipHit);
      op(`PSQ_OP_DI, 2'h1, 14'h0, 4'h0);
      bus(1'h0, `PSQ_REG_STATUS, 32'h0);
      chk("enable off", 1'h0, rd[18]);
    end
    bus(1'h0, 32'h3c, 32'h0);
    chk("unmapped", 32'h0, rd);
    completeRun;
  end
endmodule // psq_program_sequencer_tb_top

// file: bench/psq_rom_model.sv
// pattern rom standing in for the on-chip program memory
`timescale 1ns/1ps
module psq_rom_model (
  input  logic [13:0] romAddr,
  output logic [9:0]  romData
);
  // ---------------------------------------------------------------
  // word contents
  // ---------------------------------------------------------------
  // low byte mixes page and offset to expose a wrong bank
  assign romData = {romAddr[1:0], romAddr[7:0] ^ romAddr[13:6]};
endmodule // psq_rom_model

// file: hdl/psq_defines.vh
// constants of the program sequencer and memory addressing core
`ifndef PSQ_DEFINES_VH
`define PSQ_DEFINES_VH

// ----------------------------------------------------------------
// program memory layout
// ----------------------------------------------------------------
`define PSQ_PC_W          14
`define PSQ_ROM_W         10
`define PSQ_OFS_MSB       6
`define PSQ_PAGE_LSB      7
`define PSQ_PC_RESET      14'h0000
`define PSQ_VEC_BASE      14'h0080
`define PSQ_PAGE_TWO      7'h02
`define PSQ_TBL_MSB       7

// ----------------------------------------------------------------
// data memory, pointer and display area
// ----------------------------------------------------------------
`define PSQ_RAM_DEPTH     512
`define PSQ_RAM_AW        9
`define PSQ_RAM_W         4
`define PSQ_SEG_NUM       20
`define PSQ_SEG_GROUP     1'h1
`define PSQ_SEG_FILE0     4'hc
`define PSQ_SEG_DIG0      4'h8
`define PSQ_PORTD_W       8

// ----------------------------------------------------------------
// stack and interrupt sources
// ----------------------------------------------------------------
`define PSQ_SK_DEPTH      8
`define PSQ_SP_RESET      3'h7
`define PSQ_IRQ_NUM       8

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define PSQ_OP_SEQ        5'h00
`define PSQ_OP_BRANCH     5'h01
`define PSQ_OP_CALL       5'h02
`define PSQ_OP_RET        5'h03
`define PSQ_OP_RTI        5'h04
`define PSQ_OP_TABLE      5'h05
`define PSQ_OP_P2CALL     5'h06
`define PSQ_OP_BANKHI     5'h07
`define PSQ_OP_BANKLO     5'h08
`define PSQ_OP_EI         5'h09
`define PSQ_OP_DI         5'h0a
`define PSQ_OP_RBSET      5'h0b
`define PSQ_OP_RBCLR      5'h0c
`define PSQ_OP_RBTEST     5'h0d
`define PSQ_OP_PBSET      5'h0e
`define PSQ_OP_PBCLR      5'h0f
`define PSQ_OP_PBTEST     5'h10
`define PSQ_OP_LDPTR      5'h11
`define PSQ_OP_RAMWR      5'h12
`define PSQ_OP_IRQTEST    5'h13

// ----------------------------------------------------------------
// bus register offsets and reset values
// ----------------------------------------------------------------
`define PSQ_REG_CTRL      6'h00
`define PSQ_REG_MASKONE   6'h04
`define PSQ_REG_MASKTWO   6'h08
`define PSQ_REG_STATUS    6'h0c
`define PSQ_REG_FLAGS     6'h10
`define PSQ_REG_CONTEXT   6'h14
`define PSQ_REG_TABLE     6'h18
`define PSQ_MASK_RESET    4'h0
`define PSQ_HTRANS_NSEQ   2'h2

`endif

// file: hdl/psq_program_sequencer.v
// program counter, data pointer, memories and interrupt gate of the 4-bit core
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "psq_defines.vh"

// What this block does
// - after each executed op that loads no target the counter advances by the op length in words
// - branch, call, return and table read load the counter with a target
// - counter splits into page field bits 13..7 and offset bits 6..0
// - advancing past offset 127 wraps to 0 and steps to the next page
// - ram pointer is built from group, file and digit registers
// - the digit register also selects the port-D bit for set, clear, test
// - the group register has no reset value; software loads the pointer
// - program words are 10 bits, grouped in pages of 128 words
// - table reads use pages 64..127 after upper bank, 0..63 after lower
// - accepting an interrupt loads the source vector from 0x80..0x8e
// - the page-two call reaches routines starting at 0x100..0x17f
// - a table read returns bits 7..0 of the addressed program word
// - ram words are 4 bits and bit set, clear, test work everywhere
// - data memory holds 512 words of 4 bits, addressed by the pointer
// - a 1 in the display area of ram turns its segment on
// - interrupt needs request flag, source enable and global enable all 1
// - each interrupt source branches to its own vector
// - enable op sets the global enable flag, disable op clears it
// - accepting any interrupt clears the global enable flag
// - source enable chooses interrupt or polling by its skip test
// - acceptance clears only the serviced source request flag
// - pending sources are served in fixed priority, source 0 first
// - acceptance pushes the return address onto the return stack
// - acceptance saves pointer, carry, skip and both accumulators
module psq_program_sequencer (
  input  wire                        clk_sys,
  input  wire                        rstn,
  input  wire                        hsel,
  input  wire [31:0]                 haddr,
  input  wire [1:0]                  htrans,
  input  wire                        hwrite,
  input  wire [2:0]                  hsize,
  input  wire [31:0]                 hwdata,
  input  wire                        hready,
  output wire                        hreadyout,
  output wire                        hresp,
  output reg  [31:0]                 hrdata,
  input  wire                        opValid,
  output wire                        opReady,
  input  wire [4:0]                  opCode,
  input  wire [1:0]                  opLen,
  input  wire [13:0]                 opTarget,
  input  wire [3:0]                  opData,
  input  wire [`PSQ_IRQ_NUM-1:0]     irqReq,
  input  wire                        ctxCarryIn,
  input  wire                        ctxSkipIn,
  input  wire [3:0]                  ctxAIn,
  input  wire [3:0]                  ctxBIn,
  output reg                         ctxRestore,
  output reg                         ctxCarryOut,
  output reg                         ctxSkipOut,
  output reg  [3:0]                  ctxAOut,
  output reg  [3:0]                  ctxBOut,
  output wire [`PSQ_PC_W-1:0]        romAddr,
  input  wire [`PSQ_ROM_W-1:0]       romData,
  output reg  [7:0]                  tableData,
  output reg                         tableDone,
  output reg  [3:0]                  ramRdData,
  output reg                         skipHit,
  output reg  [`PSQ_PORTD_W-1:0]     portD,
  output reg  [`PSQ_SEG_NUM*4-1:0]   segOn
);

  localparam ST_RUN   = 1'b0;
  localparam ST_TABLE = 1'b1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [`PSQ_PC_W-1:0] pcAdvance;
    input [`PSQ_PC_W-1:0] pc;
    input [1:0]           len;
    begin
      pcAdvance = pc + {12'h000, len};
    end
  endfunction

  function [2:0] firstPending;
    input [`PSQ_IRQ_NUM-1:0] pend;
    integer k;
    begin
      firstPending = 3'h0;
      for (k = `PSQ_IRQ_NUM - 1; k >= 0; k = k - 1) begin
        if (pend[k])
          firstPending = k[2:0];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [`PSQ_PC_W-1:0]       pc_q;
  reg [`PSQ_PC_W-1:0]       tblRet_q;
  reg                       state_q;
  reg [2:0]                 sp_q;
  reg [`PSQ_PC_W-1:0]       stack_q [0:`PSQ_SK_DEPTH-1];
  reg                       grp_q;
  reg [3:0]                 file_q;
  reg [3:0]                 dig_q;
  reg [`PSQ_RAM_W-1:0]      ram_q [0:`PSQ_RAM_DEPTH-1];
  reg                       bankHi_q;
  reg                       global_irq_enable_flag_q;
  reg                       eiWait_q;
  reg [3:0]                 maskOne_q;
  reg [3:0]                 maskTwo_q;
  reg [`PSQ_IRQ_NUM-1:0]    reqFlag_q;
  reg [`PSQ_IRQ_NUM-1:0]    reqFlag_d;
  reg [`PSQ_RAM_AW-1:0]     savePtr_q;
  reg                       saveCarry_q;
  reg                       saveSkip_q;
  reg [3:0]                 saveA_q;
  reg [3:0]                 saveB_q;
  reg [5:0]                 busAddr_q;
  reg                       busWr_q;

  wire [`PSQ_RAM_AW-1:0]    ramPtr   = {grp_q, file_q, dig_q};
  wire [`PSQ_RAM_W-1:0]     ramWord  = ram_q[ramPtr];
  wire [`PSQ_IRQ_NUM-1:0]   irqMask  = {maskTwo_q, maskOne_q};
  wire [`PSQ_IRQ_NUM-1:0]   pending  = reqFlag_q & irqMask;
  wire                      irqTake  = (state_q == ST_RUN) & global_irq_enable_flag_q & ~eiWait_q & (|pending);
  wire [2:0]                irqSrc   = firstPending(pending);
  wire                      opFire   = opValid & opReady;
  wire [`PSQ_PC_W-1:0]      pcNext   = pcAdvance(pc_q, opLen);
  wire [2:0]                spUp     = sp_q + 3'h1;
  wire [`PSQ_PC_W-1:0]      tblAddr  = {bankHi_q, opTarget[5:0], opTarget[9:7], opData};
  wire [`PSQ_PC_W-1:0]      irqVec   = `PSQ_VEC_BASE | {10'h000, irqSrc, 1'b0};
  wire                      busReq   = hsel & htrans[1] & hready;

  assign opReady   = (state_q == ST_RUN) & ~irqTake;
  assign romAddr   = pc_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // program counter, stack and context store
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pc_q        <= `PSQ_PC_RESET;
      tblRet_q    <= `PSQ_PC_RESET;
      state_q     <= ST_RUN;
      sp_q        <= `PSQ_SP_RESET;
      tableData   <= 8'h00;
      tableDone   <= 1'b0;
      ctxRestore  <= 1'b0;
      ctxCarryOut <= 1'b0;
      ctxSkipOut  <= 1'b0;
      ctxAOut     <= 4'h0;
      ctxBOut     <= 4'h0;
      savePtr_q   <= {`PSQ_RAM_AW{1'b0}};
      saveCarry_q <= 1'b0;
      saveSkip_q  <= 1'b0;
      saveA_q     <= 4'h0;
      saveB_q     <= 4'h0;
    end else begin
      tableDone  <= 1'b0;
      ctxRestore <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (irqTake) begin
            pc_q        <= irqVec;
            sp_q        <= spUp;
            savePtr_q   <= ramPtr;
            saveCarry_q <= ctxCarryIn;
            saveSkip_q  <= ctxSkipIn;
            saveA_q     <= ctxAIn;
            saveB_q     <= ctxBIn;
          end else if (opFire) begin
            case (opCode)
              `PSQ_OP_BRANCH: pc_q <= opTarget;
              `PSQ_OP_CALL: begin
                pc_q <= opTarget;
                sp_q <= spUp;
              end
              `PSQ_OP_P2CALL: begin
                // only the start is fixed to page two; the routine may run on past it
                pc_q <= {`PSQ_PAGE_TWO, opTarget[`PSQ_OFS_MSB:0]};
                sp_q <= spUp;
              end
              `PSQ_OP_RET: begin
                pc_q <= stack_q[sp_q];
                sp_q <= sp_q - 3'h1;
              end
              `PSQ_OP_RTI: begin
                pc_q        <= stack_q[sp_q];
                sp_q        <= sp_q - 3'h1;
                ctxRestore  <= 1'b1;
                ctxCarryOut <= saveCarry_q;
                ctxSkipOut  <= saveSkip_q;
                ctxAOut     <= saveA_q;
                ctxBOut     <= saveB_q;
              end
              `PSQ_OP_TABLE: begin
                // the counter itself fetches the table word, so the fetch path needs no second port
                tblRet_q <= pcNext;
                pc_q     <= tblAddr;
                state_q  <= ST_TABLE;
              end
              default: pc_q <= pcNext;
            endcase
          end
        end
        ST_TABLE: begin
          tableData <= romData[`PSQ_TBL_MSB:0];
          tableDone <= 1'b1;
          pc_q      <= tblRet_q;
          state_q   <= ST_RUN;
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // stack words hold no control state, so they carry no reset
  always @(posedge clk_sys) begin
    if (irqTake)
      stack_q[spUp] <= pc_q;
    else if (opFire && (opCode == `PSQ_OP_CALL || opCode == `PSQ_OP_P2CALL))
      stack_q[spUp] <= pcNext;
  end

  // ----------------------------------------------------------------
  // data pointer and data memory
  // ----------------------------------------------------------------
  // the group register is left without reset on purpose; software must load it
  always @(posedge clk_sys) begin
    if (opFire && opCode == `PSQ_OP_LDPTR)
      grp_q <= opTarget[8];
    else if (opFire && opCode == `PSQ_OP_RTI)
      grp_q <= savePtr_q[8];
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      file_q <= 4'h0;
      dig_q  <= 4'h0;
    end else if (opFire && opCode == `PSQ_OP_LDPTR) begin
      file_q <= opTarget[7:4];
      dig_q  <= opTarget[3:0];
    end else if (opFire && opCode == `PSQ_OP_RTI) begin
      file_q <= savePtr_q[7:4];
      dig_q  <= savePtr_q[3:0];
    end
  end

  always @(posedge clk_sys) begin
    if (opFire) begin
      case (opCode)
        `PSQ_OP_RAMWR: ram_q[ramPtr] <= opData;
        `PSQ_OP_RBSET: ram_q[ramPtr] <= ramWord | (4'h1 << opData[1:0]);
        `PSQ_OP_RBCLR: ram_q[ramPtr] <= ramWord & ~(4'h1 << opData[1:0]);
        default: ram_q[ramPtr] <= ramWord;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // display segments, port D, skip results
  // ----------------------------------------------------------------
  integer s;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      segOn <= {(`PSQ_SEG_NUM*4){1'b0}};
    end else begin
      for (s = 0; s < `PSQ_SEG_NUM; s = s + 1)
        segOn[s*4 +: 4] <= ram_q[{`PSQ_SEG_GROUP, `PSQ_SEG_FILE0 + s[6:3], `PSQ_SEG_DIG0 + {1'b0, s[2:0]}}];
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      portD     <= {`PSQ_PORTD_W{1'b0}};
      skipHit   <= 1'b0;
      ramRdData <= 4'h0;
    end else begin
      skipHit   <= 1'b0;
      ramRdData <= ramWord;
      if (opFire) begin
        case (opCode)
          `PSQ_OP_PBSET: portD[dig_q[2:0]] <= 1'b1;
          `PSQ_OP_PBCLR: portD[dig_q[2:0]] <= 1'b0;
          `PSQ_OP_PBTEST: skipHit <= ~portD[dig_q[2:0]];
          `PSQ_OP_RBTEST: skipHit <= ~ramWord[opData[1:0]];
          `PSQ_OP_IRQTEST: skipHit <= reqFlag_q[opData[2:0]] & ~irqMask[opData[2:0]];
          default: skipHit <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt gate
  // ----------------------------------------------------------------
  always @* begin
    reqFlag_d = reqFlag_q;
    if (irqTake)
      reqFlag_d[irqSrc] = 1'b0;
    if (opFire && opCode == `PSQ_OP_IRQTEST && !irqMask[opData[2:0]])
      reqFlag_d[opData[2:0]] = 1'b0;
    if (busWr_q && busAddr_q == `PSQ_REG_FLAGS)
      reqFlag_d = reqFlag_d & ~hwdata[`PSQ_IRQ_NUM-1:0];
    // a request arriving with its clear is kept
    reqFlag_d = reqFlag_d | irqReq;
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reqFlag_q <= {`PSQ_IRQ_NUM{1'b0}};
      global_irq_enable_flag_q    <= 1'b0;
      eiWait_q  <= 1'b0;
    end else begin
      reqFlag_q <= reqFlag_d;
      if (irqTake) begin
        global_irq_enable_flag_q <= 1'b0;
      end else if (opFire) begin
        // enable takes effect only after the following op completes
        eiWait_q <= (opCode == `PSQ_OP_EI);
        if (opCode == `PSQ_OP_EI)
          global_irq_enable_flag_q <= 1'b1;
        else if (opCode == `PSQ_OP_DI)
          global_irq_enable_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite register slave, zero wait states
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busAddr_q <= 6'h00;
      busWr_q   <= 1'b0;
      hrdata    <= 32'h00000000;
      bankHi_q  <= 1'b0;
      maskOne_q <= `PSQ_MASK_RESET;
      maskTwo_q <= `PSQ_MASK_RESET;
    end else begin
      busWr_q   <= busReq & hwrite;
      busAddr_q <= haddr[5:0];
      if (busWr_q) begin
        case (busAddr_q)
          `PSQ_REG_CTRL: bankHi_q <= hwdata[0];
          `PSQ_REG_MASKONE: maskOne_q <= hwdata[3:0];
          `PSQ_REG_MASKTWO: maskTwo_q <= hwdata[3:0];
          default: bankHi_q <= bankHi_q;
        endcase
      end
      if (opFire && opCode == `PSQ_OP_BANKHI)
        bankHi_q <= 1'b1;
      else if (opFire && opCode == `PSQ_OP_BANKLO)
        bankHi_q <= 1'b0;
      if (busReq && !hwrite && haddr[31:6] == 26'h0000000) begin
        case (haddr[5:0])
          `PSQ_REG_CTRL: hrdata <= {31'h00000000, bankHi_q};
          `PSQ_REG_MASKONE: hrdata <= {28'h0000000, maskOne_q};
          `PSQ_REG_MASKTWO: hrdata <= {28'h0000000, maskTwo_q};
          `PSQ_REG_STATUS: hrdata <= {11'h000, state_q, eiWait_q, global_irq_enable_flag_q, sp_q, 1'b0, pc_q};
          `PSQ_REG_FLAGS: hrdata <= {24'h000000, reqFlag_q};
          `PSQ_REG_CONTEXT: hrdata <= {13'h0000, saveCarry_q, saveSkip_q, saveB_q, saveA_q, savePtr_q};
          `PSQ_REG_TABLE: hrdata <= {24'h000000, tableData};
          default: hrdata <= 32'h00000000;
        endcase
      end else if (busReq) begin
        hrdata <= 32'h00000000;
      end
    end
  end

endmodule // psq_program_sequencer
